// [rtl/vtsup_cfg.svh]
// Constants of the voltage transformer supervision block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the block and the bench.
`ifndef VTSUP_CFG_SVH
`define VTSUP_CFG_SVH
// =====================================================================
// Register offsets (byte addresses)
`define VTSUP_OFF_CTRL     8'h00
`define VTSUP_OFF_LOW      8'h04
`define VTSUP_OFF_HIGH     8'h08
`define VTSUP_OFF_ANGLE    8'h0c
`define VTSUP_OFF_DELAY    8'h10
`define VTSUP_OFF_STATUS   8'h14
`define VTSUP_OFF_IRQ_STAT 8'h18
`define VTSUP_OFF_IRQ_MASK 8'h1c
// =====================================================================
// Control fields
`define VTSUP_CTRL_ALLOW   3
`define VTSUP_CTRL_FORCE   4
`define VTSUP_CTRL_BUSCHK  8
`define VTSUP_CTRL_LINECHK 9
// =====================================================================
// Settings: magnitudes in 0.01 x nominal_voltage, angles in 0.1 deg
`define VTSUP_LOW_MIN   12'h005
`define VTSUP_LOW_MAX   12'h032
`define VTSUP_LOW_RST   12'h005
`define VTSUP_HIGH_MIN  12'h001
`define VTSUP_HIGH_MAX  12'h06e
`define VTSUP_HIGH_RST  12'h050
`define VTSUP_ANG_MIN   12'h014
`define VTSUP_ANG_MAX   12'h384
`define VTSUP_ANG_RST   12'h032
`define VTSUP_ANG_FULL  12'he10
`define VTSUP_ANG_HALF  12'h708
`define VTSUP_SEQ_FWD   12'h4b0
`define VTSUP_SEQ_REV   12'h960
`define VTSUP_SEQ_TOL   12'h064
`define VTSUP_DELAY_RST 16'h0014
// =====================================================================
// Timing
`define VTSUP_CLK_PS    4000
`define VTSUP_TICK_MS   5
`define VTSUP_HIST_MS   40
`endif

// [rtl/vtsup_core.sv]
// Voltage transformer supervision: three-phase level and four-channel angle-jump checks on a 5 ms tick, AXI4-Lite registers.
// Assumes magnitudes and angles arrive on core_clk_in; fuse and block inputs are pins.
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "vtsup_cfg.svh"
module vtsup_core #(
  parameter int TICK_CYCLES = (`VTSUP_TICK_MS * 1000000) / (`VTSUP_CLK_PS / 1000),
  parameter int HIST_DEPTH  = `VTSUP_HIST_MS / `VTSUP_TICK_MS
) (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  // Measurement front end
  input  wire logic [47:0] mag_in,
  input  wire logic [47:0] angle_in,
  // Pins
  input  wire logic        bus_breaker_trip_input_in,
  input  wire logic        line_breaker_trip_input_in,
  input  wire logic        block_in,
  // AXI4-Lite
  input  wire logic [7:0]  awaddr_in,
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  output logic [1:0]       bresp_out,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  input  wire logic [7:0]  araddr_in,
  input  wire logic        arvalid_in,
  output logic             arready_out,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  output logic             rvalid_out,
  input  wire logic        rready_in,
  // Results
  output logic             start_out,
  output logic             alarm_out,
  output logic             line_transformer_fail_out,
  output logic             bus_transformer_fail_out,
  output logic             blocked_out,
  output logic [2:0]       status_out,
  output logic [2:0]       bus_state_out,
  output logic             irq_out
);
  // =====================================================================
  // Helpers
  function automatic logic [11:0] clamp(input logic [11:0] v, lo, hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
  // Shortest angular distance, wrapped at a full turn
  function automatic logic [11:0] ang_dist(input logic [11:0] a, b);
    logic [11:0] d;
    d = (a >= b) ? a - b : b - a;
    ang_dist = (d > `VTSUP_ANG_HALF) ? `VTSUP_ANG_FULL - d : d;
  endfunction
  function automatic logic near(input logic [11:0] v, t);
    near = ((v >= t) ? v - t : t - v) <= `VTSUP_SEQ_TOL;
  endfunction
  // Lead of a over b within one turn; 13 bits so the sum cannot overflow
  function automatic logic [11:0] ang_lead(input logic [11:0] a, b);
    logic [12:0] s;
    s = {1'b0, a} + 13'(`VTSUP_ANG_FULL) - {1'b0, b};
    ang_lead = (s >= 13'(`VTSUP_ANG_FULL)) ? 12'(s - 13'(`VTSUP_ANG_FULL)) : s[11:0];
  endfunction
  // =====================================================================
  // Settings and status registers
  vtsup_pkg::vtsup_mode_t   mode_reg;
  vtsup_pkg::vtsup_status_t force_sel_reg;
  vtsup_pkg::vtsup_status_t stat_next;
  vtsup_pkg::vtsup_bus_t    bus_next;
  logic        allow_reg, force_reg, bus_chk_reg, line_chk_reg;
  logic [11:0] low_reg, high_reg, ang_lim_reg;
  logic [15:0] delay_reg, dly_cnt_reg;
  logic [4:0]  irq_stat_reg, irq_mask_reg, ev;
  logic [31:0] st_word;
  // =====================================================================
  // Pin synchronisers: a change counts once stages two and three agree
  logic [2:0] s_bus, s_line, s_blk;
  logic       bus_f_reg, line_f_reg, blk_f_reg;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_bus <= 3'h0; s_line <= 3'h0; s_blk <= 3'h0;
      bus_f_reg <= 1'b0; line_f_reg <= 1'b0; blk_f_reg <= 1'b0;
    end else begin
      s_bus  <= {s_bus[1:0], bus_breaker_trip_input_in};
      s_line <= {s_line[1:0], line_breaker_trip_input_in};
      s_blk  <= {s_blk[1:0], block_in};
      if (s_bus[1] == s_bus[2]) bus_f_reg <= s_bus[2];
      if (s_line[1] == s_line[2]) line_f_reg <= s_line[2];
      if (s_blk[1] == s_blk[2]) blk_f_reg <= s_blk[2];
    end
  end
  // =====================================================================
  // 5 ms evaluation tick
  logic [31:0] tick_cnt_reg;
  logic        tick_reg;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt_reg <= 32'h0;
      tick_reg     <= 1'b0;
    end else begin
      tick_reg     <= (tick_cnt_reg == 32'(TICK_CYCLES - 1));
      tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt_reg + 32'h1;
    end
  end
  // =====================================================================
  // Angle history: the oldest entry is 40 ms old once the pipe fills
  logic [11:0] hist [4][HIST_DEPTH];
  logic [11:0] mag_reg [4];
  logic [11:0] ang_reg [4];
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int c = 0; c < 4; c++) begin
        mag_reg[c] <= 12'h0;
        ang_reg[c] <= 12'h0;
        for (int k = 0; k < HIST_DEPTH; k++) hist[c][k] <= 12'h0;
      end
    end else if (tick_reg) begin
      for (int c = 0; c < 4; c++) begin
        mag_reg[c] <= mag_in[c*12 +: 12];
        ang_reg[c] <= angle_in[c*12 +: 12];
        hist[c][0] <= ang_reg[c];
        for (int k = 1; k < HIST_DEPTH; k++) hist[c][k] <= hist[c][k-1];
      end
    end
  end
  // =====================================================================
  // Pick-up and sequence decisions on the latched phases
  logic [2:0] below, above;
  logic       low_any, high_two, jump, pick, dead, seq_fwd, seq_rev;
  always_comb begin
    jump = 1'b0;
    for (int c = 0; c < 3; c++) begin
      below[c] = mag_reg[c] < low_reg;
      above[c] = mag_reg[c] > high_reg;
    end
    for (int c = 0; c < 4; c++)
      jump = jump | (ang_dist(ang_reg[c], hist[c][HIST_DEPTH-1]) >= ang_lim_reg);
    low_any  = |below;
    high_two = (above[0] & above[1]) | (above[0] & above[2]) | (above[1] & above[2]);
    pick     = (low_any | high_two) & jump;
    dead     = &below;
    seq_fwd  = near(ang_lead(ang_reg[0], ang_reg[1]), `VTSUP_SEQ_FWD);
    seq_rev  = near(ang_lead(ang_reg[0], ang_reg[1]), `VTSUP_SEQ_REV);
    if (dead) bus_next = vtsup_pkg::VTSUP_BUS_DEAD;
    else if (pick) bus_next = vtsup_pkg::VTSUP_LIVE_PROBLEM;
    else if (seq_fwd) bus_next = vtsup_pkg::VTSUP_LIVE_OK;
    else if (seq_rev) bus_next = vtsup_pkg::VTSUP_LIVE_REV;
    else bus_next = vtsup_pkg::VTSUP_LIVE_UNDEF;
  end
  // =====================================================================
  // Status evaluation, once per tick
  logic blk;
  assign blk = blk_f_reg | (mode_reg == vtsup_pkg::VTSUP_BLOCKED) |
               (mode_reg == vtsup_pkg::VTSUP_TEST_BLOCKED);
  always_comb begin
    if (bus_chk_reg && bus_f_reg) stat_next = vtsup_pkg::VTSUP_BUS_FAIL;
    else if (line_chk_reg && line_f_reg) stat_next = vtsup_pkg::VTSUP_LINE_FAIL;
    else if (pick && blk) stat_next = vtsup_pkg::VTSUP_ST_BLOCKED;
    else if (pick) stat_next = vtsup_pkg::VTSUP_START;
    else stat_next = vtsup_pkg::VTSUP_NORMAL;
    if (force_reg) stat_next = force_sel_reg;
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_out <= 3'h0; bus_state_out <= 3'h0; start_out <= 1'b0;
      alarm_out <= 1'b0; line_transformer_fail_out <= 1'b0;
      bus_transformer_fail_out <= 1'b0; blocked_out <= 1'b0; dly_cnt_reg <= 16'h0;
    end else if (tick_reg) begin
      if (mode_reg == vtsup_pkg::VTSUP_OFF) begin
        status_out <= 3'h0; bus_state_out <= 3'h0; start_out <= 1'b0;
        alarm_out <= 1'b0; line_transformer_fail_out <= 1'b0;
        bus_transformer_fail_out <= 1'b0; blocked_out <= 1'b0; dly_cnt_reg <= 16'h0;
      end else begin
        status_out                <= stat_next;
        bus_state_out             <= bus_next;
        start_out                 <= stat_next == vtsup_pkg::VTSUP_START;
        line_transformer_fail_out <= stat_next == vtsup_pkg::VTSUP_LINE_FAIL;
        bus_transformer_fail_out  <= stat_next == vtsup_pkg::VTSUP_BUS_FAIL;
        blocked_out               <= stat_next == vtsup_pkg::VTSUP_ST_BLOCKED;
        // A block after start drops the start and restarts the delay
        if (stat_next == vtsup_pkg::VTSUP_START) begin
          if (dly_cnt_reg < delay_reg) dly_cnt_reg <= dly_cnt_reg + 16'h1;
          alarm_out <= (dly_cnt_reg + 16'h1 >= delay_reg) | alarm_out;
        end else begin
          dly_cnt_reg <= 16'h0;
          alarm_out   <= 1'b0;
        end
      end
    end
  end
  // =====================================================================
  // Interrupt sources: rising edges of the result outputs
  logic [4:0] ev_prev_reg;
  assign ev = {blocked_out, bus_transformer_fail_out, line_transformer_fail_out,
               alarm_out, start_out};
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) ev_prev_reg <= 5'h0;
    else ev_prev_reg <= ev;
  end
  // =====================================================================
  // AXI4-Lite write channel; address and data taken in either order
  logic        aw_got, w_got;
  logic [7:0]  aw_a;
  logic [31:0] w_d;
  logic [3:0]  w_s;
  logic        do_wr;
  assign do_wr = aw_got & w_got & ~bvalid_out;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_got <= 1'b0; w_got <= 1'b0; aw_a <= 8'h0; w_d <= 32'h0; w_s <= 4'h0;
      awready_out <= 1'b1; wready_out <= 1'b1; bvalid_out <= 1'b0; bresp_out <= 2'h0;
    end else begin
      if (awvalid_in && awready_out) begin
        aw_got <= 1'b1; aw_a <= awaddr_in; awready_out <= 1'b0;
      end
      if (wvalid_in && wready_out) begin
        w_got <= 1'b1; w_d <= wdata_in; w_s <= wstrb_in; wready_out <= 1'b0;
      end
      if (do_wr) begin
        bvalid_out <= 1'b1;
        bresp_out  <= (aw_a[7:2] > 6'h07) ? 2'h2 : 2'h0; // Offsets from 0x20 up give SLVERR
      end
      if (bvalid_out && bready_in) begin
        bvalid_out <= 1'b0; aw_got <= 1'b0; w_got <= 1'b0;
        awready_out <= 1'b1; wready_out <= 1'b1;
      end
    end
  end
  // Register writes; settings clamp into range so no illegal value is held
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_reg <= vtsup_pkg::VTSUP_ON; allow_reg <= 1'b0; force_reg <= 1'b0;
      force_sel_reg <= vtsup_pkg::VTSUP_NORMAL; bus_chk_reg <= 1'b1; line_chk_reg <= 1'b1;
      low_reg <= `VTSUP_LOW_RST; high_reg <= `VTSUP_HIGH_RST; ang_lim_reg <= `VTSUP_ANG_RST;
      delay_reg <= `VTSUP_DELAY_RST; irq_mask_reg <= 5'h0;
    end else if (do_wr) begin
      unique case (aw_a)
        `VTSUP_OFF_CTRL: if (w_s[0] && w_s[1]) begin
          allow_reg <= w_d[`VTSUP_CTRL_ALLOW];
          if (w_d[`VTSUP_CTRL_ALLOW] && w_d[2:0] <= 3'h4)
            mode_reg <= vtsup_pkg::vtsup_mode_t'(w_d[2:0]);
          force_reg <= w_d[`VTSUP_CTRL_FORCE];
          if (w_d[7:5] <= 3'h4) force_sel_reg <= vtsup_pkg::vtsup_status_t'(w_d[7:5]);
          bus_chk_reg  <= w_d[`VTSUP_CTRL_BUSCHK];
          line_chk_reg <= w_d[`VTSUP_CTRL_LINECHK];
        end
        `VTSUP_OFF_LOW:   if (w_s[0] && w_s[1])
          low_reg <= clamp(w_d[11:0], `VTSUP_LOW_MIN, `VTSUP_LOW_MAX);
        `VTSUP_OFF_HIGH:  if (w_s[0] && w_s[1])
          high_reg <= clamp(w_d[11:0], `VTSUP_HIGH_MIN, `VTSUP_HIGH_MAX);
        `VTSUP_OFF_ANGLE: if (w_s[0] && w_s[1])
          ang_lim_reg <= clamp(w_d[11:0], `VTSUP_ANG_MIN, `VTSUP_ANG_MAX);
        `VTSUP_OFF_DELAY: if (w_s[0] && w_s[1]) delay_reg <= w_d[15:0];
        `VTSUP_OFF_IRQ_MASK: if (w_s[0]) irq_mask_reg <= w_d[4:0];
        default: ;
      endcase
    end
  end
  // Any unmasked sticky bit
  logic irq_any;
  assign irq_any = |(irq_stat_reg & irq_mask_reg);
  // Sticky events; a new event wins over a write-one clear
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat_reg <= 5'h0;
      irq_out      <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~((do_wr && aw_a == `VTSUP_OFF_IRQ_STAT && w_s[0]) ?
                      w_d[4:0] : 5'h0)) | (ev & ~ev_prev_reg);
      irq_out      <= irq_any;
    end
  end
  // =====================================================================
  // AXI4-Lite read channel, one cycle to answer
  assign st_word = {17'h0, blk_f_reg, line_f_reg, bus_f_reg, 1'b0, jump, high_two, low_any,
                    1'b0, bus_state_out, 1'b0, status_out};
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      arready_out <= 1'b1; rvalid_out <= 1'b0; rdata_out <= 32'h0; rresp_out <= 2'h0;
    end else if (arvalid_in && arready_out) begin
      arready_out <= 1'b0; rvalid_out <= 1'b1; rresp_out <= 2'h0;
      unique case (araddr_in)
        `VTSUP_OFF_CTRL: rdata_out <= {22'h0, line_chk_reg, bus_chk_reg, force_sel_reg,
                                       force_reg, allow_reg, mode_reg};
        `VTSUP_OFF_LOW:      rdata_out <= {20'h0, low_reg};
        `VTSUP_OFF_HIGH:     rdata_out <= {20'h0, high_reg};
        `VTSUP_OFF_ANGLE:    rdata_out <= {20'h0, ang_lim_reg};
        `VTSUP_OFF_DELAY:    rdata_out <= {16'h0, delay_reg};
        `VTSUP_OFF_STATUS:   rdata_out <= st_word;
        `VTSUP_OFF_IRQ_STAT: rdata_out <= {27'h0, irq_stat_reg};
        `VTSUP_OFF_IRQ_MASK: rdata_out <= {27'h0, irq_mask_reg};
        default: begin
          rdata_out <= 32'h0;
          rresp_out <= 2'h2;
        end
      endcase
    end else if (rvalid_out && rready_in) begin
      rvalid_out  <= 1'b0;
      arready_out <= 1'b1;
    end
  end
  // =====================================================================
  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_both_in;
    aw_got && w_got && !bvalid_out;
  endsequence
  sequence s_resp;
    bvalid_out [*1] ##0 (bresp_out == 2'h0 || bresp_out == 2'h2);
  endsequence
  logic on_tick;
  assign on_tick = tick_reg && mode_reg != vtsup_pkg::VTSUP_OFF && !force_reg;
  a_off_quiet: assert property (tick_reg && mode_reg == vtsup_pkg::VTSUP_OFF |=>
    !start_out && !alarm_out && !blocked_out) else $error("Off mode output active");
  a_force_wins: assert property (tick_reg && force_reg && mode_reg != vtsup_pkg::VTSUP_OFF
    |=> status_out == $past(force_sel_reg)) else $error("Forced status lost");
  a_low_pick: assert property (on_tick && low_any && jump && !blk &&
    !(bus_chk_reg && bus_f_reg) && !(line_chk_reg && line_f_reg) |=> start_out)
    else $error("Low voltage not picked up");
  a_block_start: assert property (on_tick && pick && blk && !(bus_chk_reg && bus_f_reg) &&
    !(line_chk_reg && line_f_reg) |=> blocked_out && !start_out)
    else $error("Block did not stop start");
  a_no_jump: assert property (on_tick && !jump && !(bus_chk_reg && bus_f_reg) &&
    !(line_chk_reg && line_f_reg) |=> status_out == 3'h0) else $error("Pick-up not held");
  a_bus_fuse: assert property (on_tick && bus_chk_reg && bus_f_reg |=>
    bus_transformer_fail_out) else $error("Bus fuse fail missed");
  a_alarm_delay: assert property ($rose(alarm_out) |-> start_out &&
    $past(dly_cnt_reg) + 16'h1 >= delay_reg) else $error("Alarm before delay");
  a_tick_space: assert property (tick_reg |=> !tick_reg [*2]) else $error("Tick too close");
  a_write_resp: assert property (s_both_in |=> s_resp) else $error("Write not answered");
  a_read_resp: assert property (arvalid_in && arready_out |=> rvalid_out ##0 !arready_out)
    else $error("Read not answered");
  a_irq_level: assert property (##1 irq_out == $past(irq_any))
    else $error("Interrupt level wrong");
endmodule

// [rtl/vtsup_pkg.sv]
// Types of the voltage transformer supervision block.
// Assumes the constants header is compiled alongside.
package vtsup_pkg;
  // =====================================================================
  // Enumerations
  typedef enum logic [2:0] {
    VTSUP_ON, VTSUP_BLOCKED, VTSUP_TEST, VTSUP_TEST_BLOCKED, VTSUP_OFF
  } vtsup_mode_t;
  typedef enum logic [2:0] {
    VTSUP_NORMAL, VTSUP_START, VTSUP_LINE_FAIL, VTSUP_BUS_FAIL, VTSUP_ST_BLOCKED
  } vtsup_status_t;
  typedef enum logic [2:0] {
    VTSUP_BUS_DEAD, VTSUP_LIVE_OK, VTSUP_LIVE_REV, VTSUP_LIVE_UNDEF, VTSUP_LIVE_PROBLEM
  } vtsup_bus_t;
endpackage

// [tb/tb.sv]
// Bench of the supervision block: AXI4-Lite tasks and front-end scenes.
// Assumes a 20-cycle tick in place of 5 ms; pins and bus are driven here.
`timescale 1ns/1ps
`include "vtsup_cfg.svh"
module tb;
  // ==========
  // Signals
  localparam int TK = 20;
  localparam logic [7:0]  RST_A [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h1c};
  localparam logic [31:0] RST_V [6] = '{32'h300, 32'h5, 32'h50, 32'h32, 32'h14, 32'h0};
  logic        core_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [1:0]  scene = 2'h0;
  logic        bus_trip = 1'b0, line_trip = 1'b0, blk = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        start, alarm, lfail, bfail, blocked;
  logic [1:0]  bresp, rresp, resp;
  logic [2:0]  status, bstate;
  logic [47:0] mag, ang;
  int          n_mismatch = 0;
  int          cmp_count = 0;

  // Free-running 250 MHz clock
  always #2 core_clk_in = ~core_clk_in;

  // ==========
  // Block and its measurement source
  vtsup_front #(.TICK_CYCLES(TK)) vtsup_front_i (.core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in), .scene_in(scene), .mag_out(mag), .angle_out(ang));
  vtsup_core #(.TICK_CYCLES(TK)) vtsup_core_i (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .mag_in(mag), .angle_in(ang),
    .bus_breaker_trip_input_in(bus_trip), .line_breaker_trip_input_in(line_trip),
    .block_in(blk), .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
    .wdata_in(wdata), .wstrb_in(4'hf), .wvalid_in(wvalid), .wready_out(wready),
    .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready), .araddr_in(araddr),
    .arvalid_in(arvalid), .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp),
    .rvalid_out(rvalid), .rready_in(rready), .start_out(start), .alarm_out(alarm),
    .line_transformer_fail_out(lfail), .bus_transformer_fail_out(bfail),
    .blocked_out(blocked), .status_out(status), .bus_state_out(bstate), .irq_out(irq));

  // ==========
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address and data go out together; each drops once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 200);
    if (!(bvalid && bready)) n_mismatch++;
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge core_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 200);
    if (!(rvalid && rready)) n_mismatch++;
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    wr(a, d);
    chk({30'h0, resp}, 32'h0);
    rd_reg(a);
    chk(rd, e);
  endtask

  // Outputs move one tick after the data is latched, so three ticks cover it
  task automatic ticks(input int k);
    repeat (k * TK) @(posedge core_clk_in);
  endtask

  task automatic end_test(input string name);
    $display("Test done: %0s", name);
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Tests need about 75 ticks; a wide margin before a hang is cut
  initial begin
    repeat (400 * TK) @(posedge core_clk_in);
    n_mismatch++;
    finish_test();
  end

  // ==========
  // Tests
  initial begin
    repeat (10) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd_reg(RST_A[i]);
      chk(rd, RST_V[i]);
    end
    rd_reg(8'h20);
    chk({30'h0, resp}, 32'h2);
    chk(rd, 32'h0);
    end_test("reset values");
    wr_rd(`VTSUP_OFF_LOW, 32'h64, 32'h32);
    wr_rd(`VTSUP_OFF_HIGH, 32'h0, 32'h1);
    wr_rd(`VTSUP_OFF_HIGH, 32'h50, 32'h50);
    wr_rd(`VTSUP_OFF_ANGLE, 32'hfff, 32'h384);
    wr_rd(`VTSUP_OFF_ANGLE, 32'h32, 32'h32);
    wr_rd(`VTSUP_OFF_DELAY, 32'h2, 32'h2);
    wr(8'h20, 32'h1);
    chk({30'h0, resp}, 32'h2);
    end_test("settings");
    ticks(3);
    chk({26'h0, bstate, status}, 32'h8);
    scene <= 2'h1;
    ticks(3);
    chk(32'(bstate), 32'h2);
    scene <= 2'h2;
    ticks(12);
    chk({26'h0, bstate, status}, 32'h21);
    chk({30'h0, start, alarm}, 32'h3);
    rd_reg(`VTSUP_OFF_STATUS);
    chk(rd, 32'h541);
    wr_rd(`VTSUP_OFF_HIGH, 32'h3c, 32'h3c);
    rd_reg(`VTSUP_OFF_STATUS);
    chk(rd, 32'h741);
    chk(32'(irq), 32'h0);
    rd_reg(`VTSUP_OFF_IRQ_STAT);
    chk(rd, 32'h3);
    wr(`VTSUP_OFF_IRQ_MASK, 32'h1);
    ticks(1);
    chk(32'(irq), 32'h1);
    wr(`VTSUP_OFF_IRQ_STAT, 32'h3);
    ticks(1);
    chk(32'(irq), 32'h0);
    end_test("pick-up, alarm and interrupt");
    // An 80 deg swing over 40 ms stays under a 90 deg limit
    wr(`VTSUP_OFF_ANGLE, 32'h384);
    ticks(3);
    chk(32'(status), 32'h0);
    // A longer delay so the block below lands well before it expires
    wr_rd(`VTSUP_OFF_DELAY, 32'h8, 32'h8);
    wr(`VTSUP_OFF_ANGLE, 32'h32);
    ticks(3);
    chk(32'(status), 32'h1);
    blk <= 1'b1;
    ticks(3);
    chk({29'h0, status}, 32'h4);
    chk({29'h0, start, alarm, blocked}, 32'h1);
    bus_trip <= 1'b1;
    line_trip <= 1'b1;
    ticks(3);
    chk({28'h0, bfail, status}, 32'hb);
    wr(`VTSUP_OFF_CTRL, 32'h200);
    ticks(3);
    chk({27'h0, bfail, lfail, status}, 32'ha);
    end_test("block and fuses");
    bus_trip <= 1'b0;
    line_trip <= 1'b0;
    blk <= 1'b0;
    for (int s = 0; s < 5; s++) begin
      wr(`VTSUP_OFF_CTRL, 32'h310 | (32'(s) << 5));
      ticks(3);
      chk(32'(status), 32'(s));
    end
    wr(`VTSUP_OFF_CTRL, 32'h304);
    rd_reg(`VTSUP_OFF_CTRL);
    chk(rd & 32'h7, 32'h0);
    for (int m = 0; m < 5; m++) begin
      wr(`VTSUP_OFF_CTRL, 32'h308 | 32'(m));
      ticks(3);
      chk(32'(status), (m == 4) ? 32'h0 : (m % 2 == 1) ? 32'h4 : 32'h1);
    end
    chk({24'h0, status, start, alarm, lfail, bfail, blocked}, 32'h0);
    end_test("forcing and modes");
    finish_test();
  end
endmodule

// [tb/vtsup_front.sv]
// Behavioural measurement front end: four magnitudes and four angles.
// Assumes the block's clock and reset; scene_in picks the waveform.
`timescale 1ns/1ps
module vtsup_front #(
  parameter int TICK_CYCLES = 20
) (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  // Scene: 0 healthy, 1 reversed, 2 channel 0 lost and spinning
  input  wire logic [1:0]  scene_in,
  // Measurements
  output logic      [47:0] mag_out,
  output logic      [47:0] angle_out
);
  // ==========
  // Refresh
  logic [15:0] cnt_reg;
  logic [11:0] spin_reg;

  // New values once a tick, 10 deg a step so 40 ms spans 80 deg
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg  <= 16'h0000;
      spin_reg <= 12'h000;
    end else if (cnt_reg == 16'(TICK_CYCLES - 1)) begin
      cnt_reg  <= 16'h0000;
      spin_reg <= (spin_reg >= 12'hdac) ? spin_reg - 12'hdac : spin_reg + 12'h064;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // Phases at 0.70 of nominal, 120 deg apart; fourth input follows phase A
  always_comb begin
    mag_out   = {4{12'h046}};
    angle_out = {12'h4b0, 12'h960, 12'h000, 12'h4b0};
    if (scene_in == 2'h1) begin
      angle_out = {12'h000, 12'h960, 12'h4b0, 12'h000};
    end
    if (scene_in == 2'h2) begin
      mag_out[11:0]   = 12'h000;
      angle_out[11:0] = spin_reg;
    end
  end
endmodule
